//--- hw/ddr_seq_params.svh
// Constants for the burst and self-refresh sequencing block.
`ifndef DDR_SEQ_PARAMS_SVH
`define DDR_SEQ_PARAMS_SVH
`define BURST_LEN4 4'h4
`define BURST_LEN8 4'h8
`define ADDITIVE_LAT_RST 3'h0
`define COLUMN_LAT_RST 3'h3
`define BURST_LEN_RST 4'h4
`endif

//--- hw/ddr_seq_pkg.sv
// Types shared by the burst and self-refresh sequencing block.
`default_nettype none
package ddr_seq_pkg;
    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_ACT,
        CMD_RD,
        CMD_WR,
        CMD_PRE,
        CMD_SRE,
        CMD_SRX
    } cmd_op_t;
    typedef struct packed {
        cmd_op_t op;
        logic [2:0] bank;
    } cmd_t;
    typedef struct packed {
        logic [2:0] additive_latency;
        logic [2:0] column_access_latency;
        logic [3:0] burst_length;
    } mode_cfg_t;
endpackage : ddr_seq_pkg
`default_nettype wire

//--- hw/ddr_seq.sv
// Device-side burst streamer and self-refresh state tracker.
`include "ddr_seq_params.svh"
`timescale 1ns/1ns
`default_nettype none
// ============================================================
module ddr_seq
    import ddr_seq_pkg::*;
#(
    parameter int NBANK = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire cmd_t cmd_in,
    input wire mode_cfg_t cfg,
    output logic rd_valid,
    output logic [2:0] rd_bank,
    output logic wr_accept,
    output logic [2:0] wr_bank,
    output logic selfrefresh,
    output logic [NBANK-1:0] bank_open,
    output logic cmd_error
);
    // ============================================================
    // Latency derivation.
    logic [3:0] read_latency;
    logic [3:0] write_latency;
    assign read_latency = {1'b0, cfg.additive_latency} + {1'b0, cfg.column_access_latency};
    assign write_latency = read_latency - 4'h1;

    logic [3:0] burst_len;
    assign burst_len = (cfg.burst_length == `BURST_LEN8) ? `BURST_LEN8 : `BURST_LEN4;

    // ============================================================
    // Delay lines: one bit per cycle carrying a burst start and its bank.
    // A shift line instead of a counter lets overlapping bursts pipeline freely.
    logic [DEPTH-1:0] rd_line_r, rd_line_nxt, wr_line_r, wr_line_nxt;
    logic [2:0] rd_bk_r [DEPTH], wr_bk_r [DEPTH];
    logic is_rd, is_wr;
    assign is_rd = (cmd_in.op == CMD_RD) && bank_open[cmd_in.bank] && !selfrefresh;
    assign is_wr = (cmd_in.op == CMD_WR) && bank_open[cmd_in.bank] && !selfrefresh;

    // Next line contents: shift down one place, insert at latency tap.
    always_comb begin
        rd_line_nxt = rd_line_r >> 1;
        wr_line_nxt = wr_line_r >> 1;
        if (is_rd && read_latency != 4'h0) begin
            rd_line_nxt[read_latency - 4'h1] = 1'b1;
        end
        if (is_wr && write_latency != 4'h0) begin
            wr_line_nxt[write_latency - 4'h1] = 1'b1;
        end
    end

    // Bank tags travel with the start bits.
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_tag
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    rd_bk_r[gi] <= 3'h0;
                    wr_bk_r[gi] <= 3'h0;
                end else begin
                    if (is_rd && gi == int'(read_latency) - 1) begin
                        rd_bk_r[gi] <= cmd_in.bank;
                    end else if (gi < DEPTH - 1) begin
                        rd_bk_r[gi] <= rd_bk_r[gi + 1];
                    end
                    if (is_wr && gi == int'(write_latency) - 1) begin
                        wr_bk_r[gi] <= cmd_in.bank;
                    end else if (gi < DEPTH - 1) begin
                        wr_bk_r[gi] <= wr_bk_r[gi + 1];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_line_r <= '0;
            wr_line_r <= '0;
        end else begin
            rd_line_r <= rd_line_nxt;
            wr_line_r <= wr_line_nxt;
        end
    end

    // ============================================================
    // Burst counters: a new start reloads the count, so a start arriving
    // exactly as the previous burst ends continues with no bubble.
    logic [3:0] rd_cnt_r, rd_cnt_nxt, wr_cnt_r, wr_cnt_nxt;
    logic [2:0] rd_bank_r, rd_bank_nxt, wr_bank_r, wr_bank_nxt;
    logic rd_start, wr_start;
    assign rd_start = rd_line_r[0];
    assign wr_start = wr_line_r[0];

    always_comb begin
        rd_cnt_nxt = (rd_cnt_r != 4'h0) ? rd_cnt_r - 4'h1 : 4'h0;
        wr_cnt_nxt = (wr_cnt_r != 4'h0) ? wr_cnt_r - 4'h1 : 4'h0;
        rd_bank_nxt = rd_bank_r;
        wr_bank_nxt = wr_bank_r;
        if (rd_start) begin
            rd_cnt_nxt = burst_len - 4'h1;
            rd_bank_nxt = rd_bk_r[0];
        end
        if (wr_start) begin
            wr_cnt_nxt = burst_len - 4'h1;
            wr_bank_nxt = wr_bk_r[0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_cnt_r <= 4'h0;
            wr_cnt_r <= 4'h0;
            rd_bank_r <= 3'h0;
            wr_bank_r <= 3'h0;
        end else begin
            rd_cnt_r <= rd_cnt_nxt;
            wr_cnt_r <= wr_cnt_nxt;
            rd_bank_r <= rd_bank_nxt;
            wr_bank_r <= wr_bank_nxt;
        end
    end

    // Data-phase strobes are one clock per beat; the first beat is the start cycle.
    assign rd_valid = rd_start || (rd_cnt_r != 4'h0);
    assign wr_accept = wr_start || (wr_cnt_r != 4'h0);
    assign rd_bank = rd_start ? rd_bk_r[0] : rd_bank_r;
    assign wr_bank = wr_start ? wr_bk_r[0] : wr_bank_r;

    // ============================================================
    // Bank and self-refresh state.  A refresh entry with any bank open is
    // flagged and ignored, since the controller owns that precondition.
    logic [NBANK-1:0] bank_open_r, bank_open_nxt;
    logic sr_r, sr_nxt, err_r, err_nxt;

    always_comb begin
        bank_open_nxt = bank_open_r;
        sr_nxt = sr_r;
        err_nxt = 1'b0;
        case (cmd_in.op)
            CMD_ACT: begin
                if (!sr_r) bank_open_nxt[cmd_in.bank] = 1'b1;
                else err_nxt = 1'b1;
            end
            CMD_PRE: begin
                bank_open_nxt[cmd_in.bank] = 1'b0;
            end
            CMD_SRE: begin
                if (bank_open_r == '0) sr_nxt = 1'b1;
                else err_nxt = 1'b1;
            end
            CMD_SRX: begin
                sr_nxt = 1'b0;
            end
            CMD_RD, CMD_WR: begin
                err_nxt = sr_r || !bank_open_r[cmd_in.bank];
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bank_open_r <= '0;
            sr_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            bank_open_r <= bank_open_nxt;
            sr_r <= sr_nxt;
            err_r <= err_nxt;
        end
    end

    assign bank_open = bank_open_r;
    assign selfrefresh = sr_r;
    assign cmd_error = err_r;

    // ============================================================
    // Checks.
    sequence s_rd_cmd;
        is_rd && read_latency == 4'h5 && burst_len == `BURST_LEN4;
    endsequence
    sequence s_rd_data4;
        rd_valid [*4];
    endsequence
    property p_lat5;
        @(posedge clk) disable iff (rst) s_rd_cmd |-> ##5 s_rd_data4;
    endproperty
    a_lat5: assert property (p_lat5) else $error("read burst not at latency");
    property p_wl;
        @(posedge clk) disable iff (rst) (is_wr && write_latency == 4'h4) |-> ##4 wr_start;
    endproperty
    a_wl: assert property (p_wl) else $error("write not at latency minus one");
    property p_rd_seamless;
        @(posedge clk) disable iff (rst) (rd_start && burst_len == `BURST_LEN4) ##2 rd_start |-> $past(rd_valid, 1);
    endproperty
    a_rd_seamless: assert property (p_rd_seamless) else $error("read bubble");
    property p_wr_seamless;
        @(posedge clk) disable iff (rst) (wr_start && burst_len == `BURST_LEN8) |-> wr_accept [*8];
    endproperty
    a_wr_seamless: assert property (p_wr_seamless) else $error("write burst gap");
    property p_sre_idle;
        @(posedge clk) disable iff (rst) $rose(sr_r) |-> $past(bank_open_r) == '0;
    endproperty
    a_sre_idle: assert property (p_sre_idle) else $error("refresh with open bank");
    property p_closed_bank;
        @(posedge clk) disable iff (rst) (cmd_in.op == CMD_RD && !bank_open_r[cmd_in.bank]) |=> cmd_error;
    endproperty
    a_closed_bank: assert property (p_closed_bank) else $error("closed bank read unflagged");
endmodule : ddr_seq
`default_nettype wire

//--- testbench/ddr_ctl_model.sv
// Memory controller model that drives commands into the sequencing block.
`timescale 1ns/1ns
`default_nettype none
module ddr_ctl_model
    import ddr_seq_pkg::*;
#(
    parameter int TERM_OFF = 3,
    parameter int EXIT_RD = 6,
    parameter int EXIT_NONRD = 4
) (
    input wire logic clk,
    output cmd_t cmd_out
);
    // ============================================================
    // Command issue
    logic termination_control = 1'b1;
    int since = 1000;
    initial cmd_out = '{CMD_NOP, 3'h0};
    // Idle cycles carry an explicit no-op so a held command is never taken twice.
    task automatic idle();
        @(posedge clk);
        #1 cmd_out = '{CMD_NOP, 3'h0};
        since++;
        if (since == EXIT_RD) termination_control = 1'b1;
    endtask : idle
    // One command per call; exit delays stall later commands.
    task automatic issue(input cmd_op_t op, input logic [2:0] bank);
        if (op == CMD_SRE) begin
            termination_control = 1'b0;
            repeat (TERM_OFF) idle();
        end
        while (op != CMD_NOP && since < ((op == CMD_RD) ? EXIT_RD : EXIT_NONRD)) idle();
        @(posedge clk);
        #1 cmd_out = '{op, bank};
        since = (op == CMD_SRX) ? 0 : since + 1;
    endtask : issue
endmodule : ddr_ctl_model
`default_nettype wire

//--- testbench/ddr_seq_bench.sv
// Self-checking bench for the burst and self-refresh sequencing block.
`include "ddr_seq_params.svh"
`timescale 1ns/1ns
`default_nettype none
module ddr_seq_bench
    import ddr_seq_pkg::*;
;
    // ============================================================
    // Signals and reference model state
    logic clk = 1'b0;
    logic rst = 1'b1;
    mode_cfg_t cfg = '{3'h2, 3'h3, `BURST_LEN4};
    cmd_t cmd;
    logic rd_valid, wr_accept, selfrefresh, cmd_error;
    logic [2:0] rd_bank, wr_bank;
    logic [7:0] bank_open;
    logic [7:0] open_m = 8'h00;
    logic sr_m = 1'b0;
    logic [31:0] seed = 32'h26C5;
    int cyc = 0, err_count = 0, tests_run = 0, exp_err = 0, seen = 0;
    bit exp_rd [8192];
    bit exp_wr [8192];
    logic [2:0] rb [8192];
    logic [2:0] wb [8192];
    cmd_op_t p1o [16] = '{CMD_ACT, CMD_ACT, CMD_RD, CMD_RD, CMD_RD, CMD_WR, CMD_WR, CMD_WR,
        CMD_RD, CMD_SRE, CMD_PRE, CMD_PRE, CMD_SRE, CMD_RD, CMD_SRX, CMD_ACT};
    int p1b [16] = '{1, 2, 1, 2, 1, 2, 1, 1, 5, 0, 1, 2, 0, 1, 0, 1};
    ddr_seq ddr_seq_i (.clk(clk), .rst(rst), .cmd_in(cmd), .cfg(cfg), .rd_valid(rd_valid),
        .rd_bank(rd_bank), .wr_accept(wr_accept), .wr_bank(wr_bank), .selfrefresh(selfrefresh),
        .bank_open(bank_open), .cmd_error(cmd_error));
    ddr_ctl_model ddr_ctl_model_i (.clk(clk), .cmd_out(cmd));
    // Free-running clock and cycle count.
    initial forever #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[FAIL] %s expected %0h seen %0h", n, e, g);
            err_count++;
        end
    endtask : chk
    // Strobes are compared at the falling edge, where the registered outputs are settled.
    always @(negedge clk) begin
        if (!rst) begin
            chk("rd_valid", exp_rd[cyc], rd_valid);
            chk("wr_accept", exp_wr[cyc], wr_accept);
            if (exp_rd[cyc]) chk("rd_bank", rb[cyc], rd_bank);
            if (exp_wr[cyc]) chk("wr_bank", wb[cyc], wr_bank);
            if (cmd_error === 1'b1) seen++;
        end
    end
    // Issues one command, updates the reference model, then pads with no-ops.
    task automatic send(input cmd_op_t op, input int b, input int gap);
        int rd_lat, beats, c;
        rd_lat = cfg.additive_latency + cfg.column_access_latency;
        beats = (cfg.burst_length == `BURST_LEN8) ? 8 : 4;
        ddr_ctl_model_i.issue(op, b[2:0]);
        c = cyc;
        if (op == CMD_RD || op == CMD_WR) begin
            if (open_m[b] && !sr_m) begin
                for (int i = 0; i < beats; i++) begin
                    if (op == CMD_RD) {exp_rd[c+rd_lat+i], rb[c+rd_lat+i]} = {1'b1, b[2:0]};
                    else {exp_wr[c+rd_lat-1+i], wb[c+rd_lat-1+i]} = {1'b1, b[2:0]};
                end
            end else exp_err++;
        end
        if (op == CMD_ACT) begin
            if (sr_m) exp_err++;
            else open_m[b] = 1'b1;
        end
        if (op == CMD_PRE) open_m[b] = 1'b0;
        if (op == CMD_SRE) begin
            if (open_m != 8'h00) exp_err++;
            else sr_m = 1'b1;
        end
        if (op == CMD_SRX) sr_m = 1'b0;
        repeat (gap - 1) ddr_ctl_model_i.issue(CMD_NOP, 3'h0);
        chk("bank_open", open_m, bank_open);
        chk("selfrefresh", sr_m, selfrefresh);
    endtask : send
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    // ============================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        foreach (p1o[i]) send(p1o[i], p1b[i], (i == 15) ? 20 : 2);
        $display("test burst4 and self-refresh done");
        @(posedge clk);
        #1 rst = 1'b1;
        cfg = '{3'h0, 3'h3, `BURST_LEN8};
        {open_m, sr_m} = '0;
        @(posedge clk);
        #1 chk("reset outputs", 0, {rd_valid, wr_accept, selfrefresh, cmd_error, bank_open});
        rst = 1'b0;
        for (int b = 0; b < 8; b++) send(CMD_ACT, b, 2);
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            send((i < 6) ? CMD_RD : CMD_WR, seed[2:0], (i == 11) ? 20 : 4);
        end
        $display("test burst8 random banks done");
        chk("cmd_error count", exp_err, seen);
        wrap_up();
    end
endmodule : ddr_seq_bench
`default_nettype wire
